// File: logic/adcc_pkg.sv
// Purpose: Shared constants for the converter control block
// Assumes: Classic Wishbone slave, word-spaced 8-bit registers
// Notes: Register byte address is four times the printed index

package adcc_pkg;
    // -------------------------------------------------------------
    // Register indices and address width
    // -------------------------------------------------------------
    localparam logic [7:0] IDX_CONTROL = 8'h10;
    localparam logic [7:0] IDX_RES_HIGH = 8'h11;
    localparam logic [7:0] IDX_RES_LOW = 8'h12;
    localparam logic [7:0] IDX_STATUS = 8'h13;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h14;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h15;
    localparam int ADDR_W = 10;

    // -------------------------------------------------------------
    // Control and status register fields, reset values
    // -------------------------------------------------------------
    localparam int CTRL_TRIGGER_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam int CTRL_SEL_MSB = 3;
    localparam int CTRL_FORMAT_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int STATUS_DONE_BIT = 0;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // -------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------
    localparam int CONV_TIME_US = 80;
    localparam int SYS_TICK_MHZ = 1;
    localparam int CLK_MHZ = 200;
    localparam int TICK_DIV = CLK_MHZ / SYS_TICK_MHZ;
    localparam int CONV_TICKS = CONV_TIME_US * SYS_TICK_MHZ;
    localparam int RESULT_W = 12;
endpackage : adcc_pkg

// File: logic/adcc_top.sv
// Purpose: Sequencing, result registers and status for a 12-bit converter
// Assumes: Analog core delivers a code on a result port after each sample pulse
// Notes: Sequencing counts ticks of an internal 1 MHz enable

`timescale 1ns/10ps

module adcc_top #(
    parameter int TICK_DIV = adcc_pkg::TICK_DIV,
    parameter int CONV_TICKS = adcc_pkg::CONV_TICKS
) (
    input wire logic clk_i, // System clock, 200 MHz
    input wire logic rst_i, // Synchronous reset, high
    input wire logic [adcc_pkg::ADDR_W-1:0] wb_adr_i, // Byte address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic wb_we_i, // Write strobe
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic [11:0] core_code_i, // Code from analog core
    output logic core_power_o, // Analog core powered
    output logic core_sample_o, // Sample pulse to core
    output logic [2:0] source_sel_o, // Selected input
    output logic irq_o // Level interrupt
);

    // -------------------------------------------------------------
    // Conversion state
    // -------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_STORE} adcc_state_t;

    adcc_state_t state_ff;
    adcc_state_t nxt_state;
    logic [7:0] ctrl_ff;
    logic [11:0] result_ff;
    logic done_ff;
    logic [7:0] irq_stat_ff;
    logic [7:0] irq_mask_ff;
    logic [7:0] tick_cnt_ff;
    logic tick_ff;
    logic [7:0] conv_cnt_ff;
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic [11:0] code_sync1_ff;
    logic [11:0] code_sync2_ff;

    // -------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
    wire [7:0] reg_idx = wb_adr_i[adcc_pkg::ADDR_W-1:2];
    wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    wire rd_req = bus_req && !wb_we_i;
    wire wr_ctrl = wr_lane0 && (reg_idx == adcc_pkg::IDX_CONTROL);
    wire wr_mask = wr_lane0 && (reg_idx == adcc_pkg::IDX_IRQ_MASK);
    wire trigger = wr_ctrl && wb_dat_i[adcc_pkg::CTRL_TRIGGER_BIT];
    wire rd_irq_stat = rd_req && (reg_idx == adcc_pkg::IDX_IRQ_STATUS);
    wire fmt_on = ctrl_ff[adcc_pkg::CTRL_FORMAT_BIT];
    wire store_now = (state_ff == ST_STORE);

    // Formatted view: MSB dropped, remainder shifted left one
    wire [11:0] view_code = fmt_on ? {result_ff[10:0], 1'b0} : result_ff;
    wire [7:0] res_high = view_code[11:4];
    wire [7:0] res_low = {view_code[3:0], 4'h0};

    // Read mux; unmapped addresses read zero
    logic [7:0] rd_byte;
    always_comb
    begin
        case (reg_idx)
            adcc_pkg::IDX_CONTROL: rd_byte = {ctrl_ff[7:1], 1'b0};
            adcc_pkg::IDX_RES_HIGH: rd_byte = res_high;
            adcc_pkg::IDX_RES_LOW: rd_byte = res_low;
            adcc_pkg::IDX_STATUS: rd_byte = {7'h00, done_ff};
            adcc_pkg::IDX_IRQ_STATUS: rd_byte = irq_stat_ff;
            adcc_pkg::IDX_IRQ_MASK: rd_byte = irq_mask_ff;
            default: rd_byte = 8'h00;
        endcase
    end

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    // Trigger during a conversion restarts it, so each write counts
    always_comb
    begin
        case (state_ff)
            ST_IDLE: nxt_state = trigger ? ST_CONVERT : ST_IDLE;
            ST_CONVERT:
                if (trigger)
                    nxt_state = ST_CONVERT;
                else if (tick_ff && conv_cnt_ff == 8'(CONV_TICKS - 2))
                    nxt_state = ST_STORE;
                else
                    nxt_state = ST_CONVERT;
            ST_STORE: nxt_state = trigger ? ST_CONVERT : ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // 1 MHz tick derived from the bus clock
    always_ff @(posedge clk_i)
    begin
        if (rst_i || tick_cnt_ff == 8'(TICK_DIV - 1))
            tick_cnt_ff <= 8'h00;
        else
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
        tick_ff <= !rst_i && (tick_cnt_ff == 8'(TICK_DIV - 1));
    end

    // Conversion tick counter and state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= ST_IDLE;
            conv_cnt_ff <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            if (trigger)
                conv_cnt_ff <= 8'h00;
            else if (state_ff == ST_CONVERT && tick_ff)
                conv_cnt_ff <= conv_cnt_ff + 8'h01;
        end
    end

    // Core code is from another domain; two stages before use
    always_ff @(posedge clk_i)
    begin
        code_sync1_ff <= core_code_i;
        code_sync2_ff <= code_sync1_ff;
    end

    // Control, result and done flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= adcc_pkg::CTRL_RESET;
            result_ff <= 12'h000;
            done_ff <= 1'b0;
            irq_mask_ff <= adcc_pkg::MASK_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= wb_dat_i[7:0];
            if (wr_mask)
                irq_mask_ff <= wb_dat_i[7:0];
            if (store_now && !trigger)
                result_ff <= code_sync2_ff;
            if (trigger)
                done_ff <= 1'b0;
            else if (store_now)
                done_ff <= 1'b1;
        end
    end

    // Sticky event bit 0: done; a read clears unless set same cycle
    wire done_event = store_now && !trigger;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stat_ff <= 8'h00;
        else if (done_event)
            irq_stat_ff <= (rd_irq_stat ? 8'h00 : irq_stat_ff) | 8'h01;
        else if (rd_irq_stat)
            irq_stat_ff <= 8'h00;
    end

    // Bus answer one cycle after the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= bus_req;
            rdata_ff <= rd_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_power_o <= 1'b0;
            core_sample_o <= 1'b0;
            source_sel_o <= 3'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            core_power_o <= (nxt_state != ST_IDLE);
            core_sample_o <= trigger;
            source_sel_o <= wr_ctrl ? wb_dat_i[3:1] : ctrl_ff[3:1];
            irq_o <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // -------------------------------------------------------------
    // Check helpers
    // -------------------------------------------------------------
    // Edges spent converting since the last trigger; a counter keeps
    // the long time bound cheap, where a delay range would not be
    localparam int AGE_LIMIT = CONV_TICKS * TICK_DIV - 1;
    logic [15:0] conv_age_ff;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || trigger)
            conv_age_ff <= 16'h0000;
        else if (state_ff == ST_CONVERT)
            conv_age_ff <= conv_age_ff + 16'h0001;
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    a_done_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        trigger |=> !done_ff)
        else $error("done flag not cleared by trigger");

    a_done_in_time: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_CONVERT) |-> (conv_age_ff < 16'(AGE_LIMIT)))
        else $error("conversion exceeded time bound");

    a_power_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_IDLE && !trigger) |=> !core_power_o)
        else $error("core powered while idle");

    a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_req && reg_idx == adcc_pkg::IDX_STATUS) |=> wb_dat_o[0] == $past(done_ff))
        else $error("status bit wrong");

    a_format_shift: assert property (@(posedge clk_i) disable iff (rst_i)
        fmt_on |-> res_high == result_ff[10:3])
        else $error("format view wrong");

    a_plain_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !fmt_on |-> res_high == result_ff[11:4])
        else $error("upper byte wrong");

    a_select_out: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> source_sel_o == $past(wb_dat_i[3:1]))
        else $error("source select not driven");

    a_sample_start: assert property (@(posedge clk_i) disable iff (rst_i)
        trigger |=> core_sample_o && state_ff == ST_CONVERT)
        else $error("conversion not started");

    a_tick_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_ff |-> tick_cnt_ff == 8'h00 && $past(tick_cnt_ff) == 8'(TICK_DIV - 1))
        else $error("tick too fast");

    a_done_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        done_event |=> done_ff)
        else $error("done flag not set after store");

    a_result_store: assert property (@(posedge clk_i) disable iff (rst_i)
        done_event |=> result_ff == $past(code_sync2_ff))
        else $error("result not stored");

    a_power_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_CONVERT) |-> core_power_o)
        else $error("core unpowered while converting");

    a_idle_after: assert property (@(posedge clk_i) disable iff (rst_i)
        done_event |=> state_ff == ST_IDLE && !core_power_o)
        else $error("core not idle after store");

    a_low_view: assert property (@(posedge clk_i) disable iff (rst_i)
        fmt_on |-> res_low == {result_ff[2:0], 5'h00})
        else $error("formatted low byte wrong");

    a_source_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_ctrl |=> source_sel_o == $past(ctrl_ff[3:1]))
        else $error("source select drifted");

endmodule : adcc_top

// File: verification/adcc_top_bench.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Short counts TICK_DIV=4, CONV_TICKS=10 keep the run brief
// Notes: Read results are queued by the driver and checked by a monitor
`timescale 1ns/10ps
module adcc_top_bench;
    localparam int TD = 4;
    localparam int CT = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [9:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [11:0] core_code_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, core_power_o, core_sample_o, irq_o;
    logic [2:0] source_sel_o;
    logic [31:0] exp_q[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc_n = 0;
    int n_sample = 0;
    logic [15:0] lfsr = 16'h708D;
    logic [7:0] q;
    adcc_top #(.TICK_DIV(TD), .CONV_TICKS(CT)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .core_code_i(core_code_i), .core_power_o(core_power_o),
        .core_sample_o(core_sample_o), .source_sel_o(source_sel_o), .irq_o(irq_o));
    // ------------------------------------------------------------
    // Clock, cycle count and hang guard
    // ------------------------------------------------------------
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    // Counts cycles and sample pulses; ceiling well above the run length
    always @(posedge clk_i)
    begin
        cyc_n <= cyc_n + 1;
        if (core_sample_o === 1'b1) n_sample <= n_sample + 1;
        if (cyc_n == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end
    endtask : chk
    // Monitor pops the oldest note at each read answer
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
        begin
            if (exp_q[0] !== 32'hFFFF_FFFF) chk("read data", exp_q[0], wb_dat_o);
            void'(exp_q.pop_front());
        end
    end
    // One classic cycle; e of all ones marks an unchecked read
    task automatic wb(input logic we, input logic [7:0] ix, input logic [7:0] d,
                      input logic [31:0] e);
        int t;
        if (!we) exp_q.push_back(e);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_sel_i <= 4'hF;
        wb_adr_i <= {ix, 2'b00}; wb_dat_i <= {24'h0, d};
        t = 0;
        do begin @(posedge clk_i); t++; end while (wb_ack_o !== 1'b1 && t < 50);
        if (wb_ack_o !== 1'b1) n_mismatch++;
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    endtask : wb
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    // One conversion of source s in format f, polling the done flag
    task automatic conv(input logic [2:0] s, input logic f);
        int t0, n0;
        logic [11:0] c;
        lfsr = lfsr_next(lfsr);
        c = lfsr[11:0];
        core_code_i <= c;
        n0 = n_sample;
        wb(1'b1, adcc_pkg::IDX_CONTROL, {3'h0, f, s, 1'b1}, 0);
        t0 = cyc_n;
        wb(1'b0, adcc_pkg::IDX_STATUS, 0, 32'h0);
        chk("power", 1, core_power_o);
        chk("source", s, source_sel_o);
        do wb(1'b0, adcc_pkg::IDX_STATUS, 0, 32'hFFFF_FFFF); while (q[0] !== 1'b1 && cyc_n - t0 < 300);
        chk("in time", 1, (cyc_n - t0) <= CT * TD + 6);
        @(posedge clk_i);
        chk("power", 0, core_power_o);
        chk("samples", n0 + 1, n_sample);
        wb(1'b0, adcc_pkg::IDX_RES_HIGH, 0, f ? c[10:3] : c[11:4]);
        wb(1'b0, adcc_pkg::IDX_RES_LOW, 0, f ? {c[2:0], 5'h0} : {c[3:0], 4'h0});
        wb(1'b0, adcc_pkg::IDX_CONTROL, 0, {3'h0, f, s, 1'b0});
    endtask : conv
    task automatic print_verdict();
        $display("counts: checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("power idle", 0, core_power_o);
        wb(1'b0, adcc_pkg::IDX_CONTROL, 0, 32'h0);
        wb(1'b0, adcc_pkg::IDX_STATUS, 0, 32'h0);
        wb(1'b0, adcc_pkg::IDX_IRQ_MASK, 0, 32'h0);
        wb(1'b0, 8'h20, 0, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) conv(i[2:0], i[3]);
        $display("test sources done");
        wb(1'b1, adcc_pkg::IDX_RES_HIGH, 8'hFF, 0);
        wb(1'b0, adcc_pkg::IDX_RES_HIGH, 0, lfsr[10:3]);
        $display("test read only done");
        wb(1'b0, adcc_pkg::IDX_IRQ_STATUS, 0, 32'h1);
        wb(1'b1, adcc_pkg::IDX_IRQ_MASK, 8'h01, 0);
        conv(3'h6, 1'b0);
        chk("irq", 1, irq_o);
        wb(1'b0, adcc_pkg::IDX_IRQ_STATUS, 0, 32'h1);
        @(posedge clk_i);
        chk("irq clear", 0, irq_o);
        wb(1'b0, adcc_pkg::IDX_IRQ_STATUS, 0, 32'h0);
        wb(1'b1, adcc_pkg::IDX_IRQ_MASK, 8'h00, 0);
        conv(3'h7, 1'b1);
        chk("irq masked", 0, irq_o);
        wb(1'b0, adcc_pkg::IDX_IRQ_STATUS, 0, 32'h1);
        $display("test interrupt done");
        repeat (4) @(posedge clk_i);
        print_verdict();
    end
endmodule : adcc_top_bench
